// [design/lbdl_cfg.svh]
// Constants for the loopback and external data link control block
// Functional notes
// - Payload wrap sends each receive slot in the same transmit slot.
// - Wrap changes never disturb transmit alignment or clock timing.
// - Asynchronous wrap slips silently in the payload path, never reported.
// - Payload wrap keeps no multiframe; per-channel selections win.
// - Line wrap drives transmit line side with recovered rails and recovered clock.
// - Line wrap discards transmit bus data at encoder output; receive path unchanged.
// - Framer wrap: encoder rails to decoder, transmit clock to receive clock.
// - Analog wrap loops transmit line output into receive line input internally.
// - Link enable bit 7 enables link data insertion and both link clocks.
// - T1 frame select: 00 none, 01 odd from 1, 10 even from 2, 11 all.
// - E1 frame select: 00 none, 01 even from 0, 10 odd from 1, 11 all.
// - Five-bit slot picks E1 slot 0-31, T1 slot 1-24, T1 25 framing bit.
// - Each mask bit gates link clock pulses for its slot bit; LSB first.
// - Receive link data carries the whole stream while its pin is selected.
// - Selected transmit bits are sampled from link input at link clock fall.
// - One shared offline framer; its flags may show for only one clock.
// - No-candidate flag rises at search end without candidates; low otherwise.
// - Reserved bits are written zero and writes to them have no effect.
// - On alignment: success flag, clear frame loss, idle, realign timebase.
// - Expiry flag latches after the mode interval; forced search at most 24 ms.
// - Search flag rises on forced reframe or frame loss; clears forced request.
// - Direction flag updates at search start: 0 transmit bus, 1 receive line.
`ifndef LBDL_CFG_SVH
`define LBDL_CFG_SVH
// Register indices; byte address is four times the index
`define LBDL_IDX_WRAP 8'h14
`define LBDL_IDX_SLOT 8'h15
`define LBDL_IDX_MASK 8'h16
`define LBDL_IDX_STAT 8'h17
`define LBDL_IDX_CTRL 8'h1c
// Field positions
`define LBDL_WRAP_ANALOG 0
`define LBDL_WRAP_FRAMER 1
`define LBDL_WRAP_LINE 2
`define LBDL_WRAP_PAYLOAD 3
`define LBDL_WRAP_WMASK 8'h0f
`define LBDL_SLOT_EN 7
`define LBDL_SLOT_FS_HI 6
`define LBDL_SLOT_FS_LO 5
`define LBDL_CTRL_E1 0
`define LBDL_CTRL_RX_PIN 1
`define LBDL_CTRL_TX_PIN 2
`define LBDL_CTRL_RX_FORCE 3
`define LBDL_CTRL_TX_FORCE 4
`define LBDL_CTRL_ABORT 5
`define LBDL_CTRL_WMASK 8'h07
// Reset values
`define LBDL_RST_WRAP 8'h00
`define LBDL_RST_SLOT 8'h00
`define LBDL_RST_MASK 8'h00
`define LBDL_RST_CTRL 8'h00
// Frame geometry
`define LBDL_T1_LAST_BIT 8'd192
`define LBDL_E1_LAST_BIT 8'd255
`define LBDL_T1_FBIT_SLOT 5'd25
// Search intervals in microseconds and clock rate
`define LBDL_FORCED_TIMEOUT_US 24000
`define LBDL_T1_TIMEOUT_US 12000
`define LBDL_E1_TIMEOUT_US 8000
`define LBDL_MCLK_MHZ 125
`endif

// [design/lbdl_pkg.sv]
// Types shared by the loopback and external data link control block
package lbdl_pkg;
    typedef enum logic [0:0] {
        LBDL_IDLE = 1'b0,
        LBDL_SEARCH = 1'b1
    } lbdl_state_t;
    typedef enum logic [1:0] {
        LBDL_AP_IDLE = 2'b00,
        LBDL_AP_WAIT = 2'b01,
        LBDL_AP_DONE = 2'b10
    } lbdl_apb_t;
endpackage

// [design/lbdl_ctrl.sv]
// Loopback select, external data link gating and offline search status
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "lbdl_cfg.svh"
module lbdl_ctrl import lbdl_pkg::*; #(
    parameter int unsigned FORCED_TIMEOUT_CYC = `LBDL_FORCED_TIMEOUT_US * `LBDL_MCLK_MHZ,
    parameter int unsigned T1_TIMEOUT_CYC = `LBDL_T1_TIMEOUT_US * `LBDL_MCLK_MHZ,
    parameter int unsigned E1_TIMEOUT_CYC = `LBDL_E1_TIMEOUT_US * `LBDL_MCLK_MHZ
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pins from line side clock domains
    input wire logic rx_rail_pos_in,
    input wire logic rx_rail_neg_in,
    input wire logic rx_rec_clk_in,
    input wire logic tx_enc_pos_in,
    input wire logic tx_enc_neg_in,
    input wire logic tx_clock_in,
    input wire logic rx_pcm_in,
    input wire logic tx_pcm_in,
    input wire logic tx_link_data_in,
    // Same-clock framer interface
    input wire logic tx_chan_override_in,
    input wire logic rx_frame_lost_request_in,
    input wire logic tx_frame_lost_request_in,
    input wire logic search_found_in,
    input wire logic search_none_in,
    // Loopback paths
    output logic dec_pos_out,
    output logic dec_neg_out,
    output logic rx_clock_out,
    output logic tx_line_pos_out,
    output logic tx_line_neg_out,
    output logic tx_line_clk_out,
    output logic tx_pcm_out,
    output logic payload_wrap_on_out,
    output logic line_wrap_on_out,
    output logic framer_wrap_on_out,
    output logic analog_wrap_on_out,
    // External data link
    output logic rx_link_clock_out,
    output logic rx_link_data_out,
    output logic tx_link_clock_out,
    // Offline search results
    output logic frame_found_rx_out,
    output logic frame_found_tx_out
);

////////////////////////////////////////////////////////////////////////////////
// Link bit selection shared by both directions

    // True when bit idx of the frame is gated onto the link clocks
    function automatic logic link_sel(input logic [7:0] idx, input logic e1,
                                      input logic odd, input logic [7:0] slot,
                                      input logic [7:0] mask);
        logic [7:0] pos;
        logic [4:0] ts;
        logic [2:0] bi;
        logic frm_ok;
        pos = 8'h00;
        ts = 5'h00;
        bi = 3'h0;
        frm_ok = 1'b0;
        if (e1) begin
            ts = idx[7:3];
            bi = idx[2:0];
            unique case (slot[`LBDL_SLOT_FS_HI:`LBDL_SLOT_FS_LO])
                2'b00: frm_ok = 1'b0;
                2'b01: frm_ok = ~odd;
                2'b10: frm_ok = odd;
                2'b11: frm_ok = 1'b1;
            endcase
        end else begin
            if (idx == 8'h00) begin
                ts = `LBDL_T1_FBIT_SLOT;
                bi = 3'h0;
            end else begin
                pos = idx - 8'h01;
                ts = 5'(pos[7:3] + 5'h01);
                bi = pos[2:0];
            end
            unique case (slot[`LBDL_SLOT_FS_HI:`LBDL_SLOT_FS_LO])
                2'b00: frm_ok = 1'b0;
                2'b01: frm_ok = odd;
                2'b10: frm_ok = ~odd;
                2'b11: frm_ok = 1'b1;
            endcase
        end
        // LSB of the mask is the first bit on the wire
        link_sel = slot[`LBDL_SLOT_EN] & frm_ok & (ts == slot[4:0]) & mask[bi];
    endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

    localparam int NPIN = 9;
    logic [NPIN-1:0] pins_w;
    logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q;
    assign pins_w = {tx_link_data_in, tx_pcm_in, rx_pcm_in, tx_clock_in, tx_enc_neg_in,
                     tx_enc_pos_in, rx_rec_clk_in, rx_rail_neg_in, rx_rail_pos_in};

    // Three stages; a level counts only once stages two and three agree
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
            pin_prev_q <= '0;
        end else begin
            s1_q <= pins_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
            pin_prev_q <= pin_q;
        end
    end

    logic rail_p, rail_n, rclk, enc_p, enc_n, tclk, rx_bit, tx_bit, link_in;
    assign {link_in, tx_bit, rx_bit, tclk, enc_n, enc_p, rclk, rail_n, rail_p} = pin_q;

////////////////////////////////////////////////////////////////////////////////
// Registers and APB slave

    logic [7:0] wrap_q, slot_q, mask_q, ctrl_q, stat_w, rd_w;
    logic [7:0] idx_w;
    logic hit_w, wr_w, rx_force_q, tx_force_q, abort_w;
    lbdl_apb_t ap_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    assign idx_w = paddr_in[9:2];
    assign hit_w = (paddr_in[1:0] == 2'b00) && (paddr_in[11:10] == 2'b00) &&
                   (idx_w == `LBDL_IDX_WRAP || idx_w == `LBDL_IDX_SLOT ||
                    idx_w == `LBDL_IDX_MASK || idx_w == `LBDL_IDX_STAT ||
                    idx_w == `LBDL_IDX_CTRL);
    assign wr_w = psel_in & penable_in & pwrite_in & (ap_q == LBDL_AP_DONE) & hit_w;
    assign abort_w = wr_w & (idx_w == `LBDL_IDX_CTRL) & pwdata_in[`LBDL_CTRL_ABORT];

    // Read mux; the force bits read back as pending requests
    always_comb begin
        rd_w = 8'h00;
        if (idx_w == `LBDL_IDX_WRAP) rd_w = wrap_q;
        if (idx_w == `LBDL_IDX_SLOT) rd_w = slot_q;
        if (idx_w == `LBDL_IDX_MASK) rd_w = mask_q;
        if (idx_w == `LBDL_IDX_STAT) rd_w = stat_w;
        if (idx_w == `LBDL_IDX_CTRL) rd_w = {3'b000, tx_force_q, rx_force_q, ctrl_q[2:0]};
    end

    // One wait state so read data comes straight from a flop
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ap_q <= LBDL_AP_IDLE;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            unique case (ap_q)
                LBDL_AP_IDLE: if (psel_in && !penable_in) ap_q <= LBDL_AP_WAIT;
                LBDL_AP_WAIT: begin
                    ap_q <= LBDL_AP_DONE;
                    prdata_q <= {24'h000000, hit_w ? rd_w : 8'h00};
                    pslverr_q <= ~hit_w;
                end
                LBDL_AP_DONE: begin
                    ap_q <= (psel_in && !penable_in) ? LBDL_AP_WAIT : LBDL_AP_IDLE;
                    pslverr_q <= 1'b0;
                end
                default: ap_q <= LBDL_AP_IDLE;
            endcase
        end
    end
    assign pready_out = (ap_q == LBDL_AP_DONE);
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;

    // Writable registers; reserved bits are masked off
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wrap_q <= `LBDL_RST_WRAP;
            slot_q <= `LBDL_RST_SLOT;
            mask_q <= `LBDL_RST_MASK;
            ctrl_q <= `LBDL_RST_CTRL;
        end else if (wr_w) begin
            if (idx_w == `LBDL_IDX_WRAP) wrap_q <= pwdata_in[7:0] & `LBDL_WRAP_WMASK;
            if (idx_w == `LBDL_IDX_SLOT) slot_q <= pwdata_in[7:0];
            if (idx_w == `LBDL_IDX_MASK) mask_q <= pwdata_in[7:0];
            if (idx_w == `LBDL_IDX_CTRL) ctrl_q <= pwdata_in[7:0] & `LBDL_CTRL_WMASK;
        end
    end

    logic e1_w, pay_on, line_on, frm_on;
    assign e1_w = ctrl_q[`LBDL_CTRL_E1];
    assign pay_on = wrap_q[`LBDL_WRAP_PAYLOAD];
    assign line_on = wrap_q[`LBDL_WRAP_LINE];
    assign frm_on = wrap_q[`LBDL_WRAP_FRAMER];

////////////////////////////////////////////////////////////////////////////////
// Loopback muxes

    logic rx_clk_src, rx_data_src;
    // Framer wrap: receive side is fed from the encoder and transmit clock
    assign rx_clk_src = frm_on ? tclk : rclk;
    assign rx_data_src = rx_bit;

    // Registered loopback outputs; line input is simply not selected
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dec_pos_out <= 1'b0;
            dec_neg_out <= 1'b0;
            rx_clock_out <= 1'b0;
            tx_line_pos_out <= 1'b0;
            tx_line_neg_out <= 1'b0;
            tx_line_clk_out <= 1'b0;
        end else begin
            dec_pos_out <= frm_on ? enc_p : rail_p;
            dec_neg_out <= frm_on ? enc_n : rail_n;
            rx_clock_out <= rx_clk_src;
            // Rails pass as-is, so violations stay transparent
            tx_line_pos_out <= line_on ? rail_p : enc_p;
            tx_line_neg_out <= line_on ? rail_n : enc_n;
            tx_line_clk_out <= line_on ? rclk : tclk;
        end
    end
    // Analog wrap is a plain level to the line interface front end
    assign analog_wrap_on_out = wrap_q[`LBDL_WRAP_ANALOG];
    assign payload_wrap_on_out = pay_on;
    assign line_wrap_on_out = line_on;
    assign framer_wrap_on_out = frm_on;

////////////////////////////////////////////////////////////////////////////////
// Receive and transmit timebases

    logic rx_prev_clk_q, rx_rise, rx_fall, tx_rise, tx_fall;
    logic [7:0] rx_idx_q, tx_idx_q, last_w;
    logic rx_odd_q, tx_odd_q, realign_rx, realign_tx;
    assign last_w = e1_w ? `LBDL_E1_LAST_BIT : `LBDL_T1_LAST_BIT;

    // Receive clock source may swap under framer wrap, so track its own history
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) rx_prev_clk_q <= 1'b0;
        else rx_prev_clk_q <= rx_clk_src;
    end
    assign rx_rise = rx_clk_src & ~rx_prev_clk_q;
    assign rx_fall = ~rx_clk_src & rx_prev_clk_q;
    assign tx_rise = tclk & ~pin_prev_q[5];
    assign tx_fall = ~tclk & pin_prev_q[5];

    // Receive timebase; first frame after realign is frame 1 in T1, 0 in E1
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_idx_q <= 8'h00;
            rx_odd_q <= 1'b1;
        end else if (realign_rx) begin
            rx_idx_q <= 8'h00;
            rx_odd_q <= ~e1_w;
        end else if (rx_rise) begin
            rx_idx_q <= (rx_idx_q >= last_w) ? 8'h00 : 8'(rx_idx_q + 8'h01);
            if (rx_idx_q >= last_w) rx_odd_q <= ~rx_odd_q;
        end
    end

    // Transmit timebase ignores wrap settings entirely
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_idx_q <= 8'h00;
            tx_odd_q <= 1'b1;
        end else if (realign_tx) begin
            tx_idx_q <= 8'h00;
            tx_odd_q <= ~e1_w;
        end else if (tx_rise) begin
            tx_idx_q <= (tx_idx_q >= last_w) ? 8'h00 : 8'(tx_idx_q + 8'h01);
            if (tx_idx_q >= last_w) tx_odd_q <= ~tx_odd_q;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Payload wrap buffer and transmit bit insertion

    logic [255:0] pay_buf_q;
    logic tx_ovh, tx_ins, rx_sel;

    // One frame of receive bits by position; overruns just overwrite, i.e. slip
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) pay_buf_q <= '0;
        else if (rx_rise) pay_buf_q[rx_idx_q] <= rx_data_src;
    end

    // Overhead: T1 framing bit or E1 slot zero
    assign tx_ovh = e1_w ? (tx_idx_q[7:3] == 5'h00) : (tx_idx_q == 8'h00);
    assign tx_ins = ctrl_q[`LBDL_CTRL_TX_PIN] & link_sel(tx_idx_q, e1_w, tx_odd_q, slot_q, mask_q);
    assign rx_sel = ctrl_q[`LBDL_CTRL_RX_PIN] & link_sel(rx_idx_q, e1_w, rx_odd_q, slot_q, mask_q);

    // Transmit bit chosen at the falling edge, when the link input is sampled
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) tx_pcm_out <= 1'b0;
        else if (tx_fall) begin
            if (tx_ins) tx_pcm_out <= link_in;
            else if (pay_on && !tx_ovh && !tx_chan_override_in)
                tx_pcm_out <= pay_buf_q[tx_idx_q];
            else tx_pcm_out <= tx_bit;
        end
    end

    // Link clocks skip the rise cycle, where the bit index is still the old one
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_link_clock_out <= 1'b0;
            rx_link_clock_out <= 1'b0;
            rx_link_data_out <= 1'b0;
        end else begin
            tx_link_clock_out <= tx_ins & tclk & ~tx_rise;
            rx_link_clock_out <= rx_sel & rx_clk_src & ~rx_rise;
            // Full stream whenever the pin is in link mode, marked or not
            rx_link_data_out <= ctrl_q[`LBDL_CTRL_RX_PIN] & rx_data_src;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Offline framer search control

    lbdl_state_t st_q;
    logic dir_rx_q, forced_q, found_q, tmo_q, none_q;
    logic [21:0] cnt_q, lim_w;
    logic start_w, start_rx_w, end_found, end_none, end_tmo, end_abort;
    logic rx_force_set, tx_force_set;

    assign rx_force_set = wr_w & (idx_w == `LBDL_IDX_CTRL) & pwdata_in[`LBDL_CTRL_RX_FORCE];
    assign tx_force_set = wr_w & (idx_w == `LBDL_IDX_CTRL) & pwdata_in[`LBDL_CTRL_TX_FORCE];
    assign start_w = (st_q == LBDL_IDLE) &&
                     (rx_force_q || tx_force_q || rx_frame_lost_request_in ||
                      tx_frame_lost_request_in);
    // Receive requests go first when both directions ask together
    assign start_rx_w = rx_force_q | rx_frame_lost_request_in;
    assign lim_w = forced_q ? 22'(FORCED_TIMEOUT_CYC) :
                   (e1_w ? 22'(E1_TIMEOUT_CYC) : 22'(T1_TIMEOUT_CYC));
    assign end_found = (st_q == LBDL_SEARCH) & search_found_in;
    assign end_none = (st_q == LBDL_SEARCH) & ~search_found_in & search_none_in;
    assign end_tmo = (st_q == LBDL_SEARCH) & ~search_found_in & ~search_none_in &
                     (cnt_q >= 22'(lim_w - 22'h000001));
    assign end_abort = (st_q == LBDL_SEARCH) & abort_w & ~end_found & ~end_none & ~end_tmo;

    // Forced requests: a fresh write wins over the clear at search start
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_force_q <= 1'b0;
            tx_force_q <= 1'b0;
        end else begin
            rx_force_q <= rx_force_set | (rx_force_q & ~(start_w & start_rx_w));
            tx_force_q <= tx_force_set | (tx_force_q & ~(start_w & ~start_rx_w));
        end
    end

    // Search state, direction and interval counter
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= LBDL_IDLE;
            dir_rx_q <= 1'b0;
            forced_q <= 1'b0;
            cnt_q <= 22'h000000;
        end else begin
            unique case (st_q)
                LBDL_IDLE: if (start_w) begin
                    st_q <= LBDL_SEARCH;
                    dir_rx_q <= start_rx_w;
                    forced_q <= start_rx_w ? rx_force_q : tx_force_q;
                    cnt_q <= 22'h000000;
                end
                LBDL_SEARCH: begin
                    cnt_q <= 22'(cnt_q + 22'h000001);
                    if (end_found || end_none || end_tmo || end_abort) st_q <= LBDL_IDLE;
                end
            endcase
        end
    end

    // Result flags clear at every search start and latch at a found, none or timeout end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            found_q <= 1'b0;
            tmo_q <= 1'b0;
            none_q <= 1'b0;
        end else if (start_w) begin
            found_q <= 1'b0;
            tmo_q <= 1'b0;
            none_q <= 1'b0;
        end else begin
            if (end_found) found_q <= 1'b1;
            if (end_tmo) tmo_q <= 1'b1;
            if (end_none) none_q <= 1'b1;
        end
    end

    assign realign_rx = end_found & dir_rx_q;
    assign realign_tx = end_found & ~dir_rx_q;
    // Pulses tell the online framer to drop its frame-loss request
    assign frame_found_rx_out = realign_rx;
    assign frame_found_tx_out = realign_tx;
    assign stat_w = {3'b000, none_q, found_q, tmo_q, (st_q == LBDL_SEARCH), dir_rx_q};

endmodule

// [bench/lbdl_ctrl_asserts.sv]
// Port-level timing checks for the loopback and link control block
`timescale 1ns/100ps
module lbdl_ctrl_asserts (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic rx_rail_pos_in,
    input wire logic tx_line_pos_out,
    input wire logic line_wrap_on_out,
    input wire logic framer_wrap_on_out,
    input wire logic payload_wrap_on_out,
    input wire logic tx_enc_pos_in,
    input wire logic dec_pos_out,
    input wire logic search_found_in,
    input wire logic frame_found_rx_out,
    input wire logic frame_found_tx_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Six stable cycles cover the three-flop sync, the agreement flop and the output flop
    property p_apb_wait; psel_in && !penable_in |=> !pready_out ##1 pready_out; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("answer timing wrong");
    property p_hi_zero; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_line; (line_wrap_on_out && $stable(rx_rail_pos_in))[*6] |->
        tx_line_pos_out == rx_rail_pos_in; endproperty
    a_line: assert property (p_line) else $error("line wrap data lost");
    property p_frm; (framer_wrap_on_out && $stable(tx_enc_pos_in))[*6] |->
        dec_pos_out == tx_enc_pos_in; endproperty
    a_frm: assert property (p_frm) else $error("framer wrap data lost");
    property p_rst; $fell(rst_in) |-> !payload_wrap_on_out && !line_wrap_on_out; endproperty
    a_rst: assert property (p_rst) else $error("wrap active after reset");
    property p_cause; frame_found_rx_out || frame_found_tx_out |-> search_found_in; endproperty
    a_cause: assert property (p_cause) else $error("found without candidate");
    property p_pulse; frame_found_rx_out |=> !frame_found_rx_out; endproperty
    a_pulse: assert property (p_pulse) else $error("found pulse too long");
    property p_one; !(frame_found_rx_out && frame_found_tx_out); endproperty
    a_one: assert property (p_one) else $error("both directions found");
    c_found: cover property (frame_found_rx_out);
    c_both: cover property (line_wrap_on_out && framer_wrap_on_out);
    c_apb: cover property (pready_out && psel_in);
endmodule
bind lbdl_ctrl lbdl_ctrl_asserts i_chk (.*);

// [bench/lbdl_link_partner.sv]
// Far-side serial source feeding the transmit link data pin
`timescale 1ns/100ps
module lbdl_link_partner (
    input wire logic mclk_in,
    input wire logic link_clock_in,
    output logic link_data_out
);
    logic [7:0] pat_q = 8'h4d;
    logic clk_q = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // New bit at each rising link clock, held past the falling edge
    always @(posedge mclk_in) begin
        clk_q <= link_clock_in;
        if (link_clock_in && !clk_q) begin
            link_data_out <= pat_q[0];
            pat_q <= {pat_q[0], pat_q[7:1]};
        end else if (!link_clock_in && !clk_q) begin
            link_data_out <= ~link_data_out; // Toggles every cycle while the clock stays low, no steady value
        end
    end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the loopback and link control block
`timescale 1ns/100ps
module testbench;
    logic mclk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, rd;
    logic pready_out, pslverr_out, err, tx_clock_in = 1'b0, rx_rec_clk_in, tx_link_data_in;
    logic rx_rail_pos_in, rx_rail_neg_in, tx_enc_pos_in, tx_enc_neg_in, rx_pcm_in, tx_pcm_in;
    logic tx_chan_override_in = 1'b0, rx_frame_lost_request_in = 1'b0;
    logic tx_frame_lost_request_in = 1'b0, search_found_in = 1'b0, search_none_in = 1'b0;
    logic dec_pos_out, dec_neg_out, rx_clock_out, tx_line_pos_out, tx_line_neg_out;
    logic tx_line_clk_out, tx_pcm_out, payload_wrap_on_out, line_wrap_on_out;
    logic framer_wrap_on_out, analog_wrap_on_out, rx_link_clock_out, rx_link_data_out;
    logic tx_link_clock_out, frame_found_rx_out, frame_found_tx_out;
    logic tx_q = 1'b0, rx_q = 1'b0;
    logic [6:0] slow_q = '0;
    int err_total = 0, num_checks = 0, tx_n = 0, rx_n = 0, t0, r0;
    // Register rows: address, write, read-back, error
    logic [11:0] ra [7] = '{12'h050, 12'h054, 12'h058, 12'h05c, 12'h060, 12'h052, 12'h070};
    logic [7:0] rw [7] = '{8'hff, 8'he3, 8'ha5, 8'hff, 8'h11, 8'h11, 8'h07};
    logic [7:0] rv [7] = '{8'h0f, 8'he3, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h07};
    logic re [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    // Link rows: control, slot, mask, pulses per two frames
    logic [7:0] lc [8] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h07, 8'h07};
    logic [7:0] ls [8] = '{8'he3, 8'ha3, 8'hc3, 8'h83, 8'h63, 8'hf9, 8'ha0, 8'hdf};
    logic [7:0] lm [8] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'hff, 8'h80};
    int lx [8] = '{4, 2, 2, 0, 0, 2, 8, 1};
    ////////////////////////////////////////////////////////////////////////////////
    // Transmit clock, also used as recovered clock, offset from the system clock edges
    always #4 mclk_in = ~mclk_in;
    initial #1.3 forever #62.5 tx_clock_in = ~tx_clock_in;
    assign rx_rec_clk_in = tx_clock_in;
    assign {tx_enc_neg_in, tx_enc_pos_in, rx_rail_pos_in} = slow_q[6:4];
    assign {rx_rail_neg_in, rx_pcm_in, tx_pcm_in} = slow_q[3:1];
    // Slow line patterns and link clock pulse counts
    always @(posedge mclk_in) begin
        slow_q <= slow_q + 7'h01;
        tx_q <= tx_link_clock_out;
        rx_q <= rx_link_clock_out;
        tx_n <= tx_n + int'(tx_link_clock_out && !tx_q);
        rx_n <= rx_n + int'(rx_link_clock_out && !rx_q);
    end
    lbdl_ctrl #(.FORCED_TIMEOUT_CYC(40), .T1_TIMEOUT_CYC(20), .E1_TIMEOUT_CYC(16)) i_dut (.*);
    lbdl_link_partner i_far (.mclk_in, .link_clock_in(tx_link_clock_out),
        .link_data_out(tx_link_data_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= {24'h0, d};
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    function automatic logic [32:0] wraps();
        return {29'h0, payload_wrap_on_out, line_wrap_on_out, framer_wrap_on_out,
            analog_wrap_on_out};
    endfunction
    task automatic status(input logic [32:0] exp);
        apb(1'b0, 12'h05c, 8'h00);
        chk({err, rd}, exp);
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ra[i], rw[i]);
            chk({err, 32'h0}, {re[i], 32'h0});
            apb(1'b0, ra[i], 8'h00);
            chk({err, rd}, {re[i], 24'h0, rv[i]});
        end
        chk(wraps(), 33'h0f);
        rst_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        chk(wraps(), 33'h00);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ra[i], 8'h00);
            chk({err, rd}, 33'h0);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h070, lc[i]);
            apb(1'b1, 12'h054, ls[i]);
            apb(1'b1, 12'h058, lm[i]);
            repeat (3) @(posedge tx_clock_in);
            t0 = tx_n;
            r0 = rx_n;
            repeat (lc[i][0] ? 512 : 386) @(posedge tx_clock_in);
            chk(33'(tx_n - t0), 33'(lx[i]));
            chk(33'(rx_n - r0), 33'(lx[i]));
        end
        apb(1'b1, 12'h070, 8'h0f);
        status(33'h03);
        search_found_in <= 1'b1;
        @(posedge mclk_in);
        search_found_in <= 1'b0;
        status(33'h09);
        apb(1'b1, 12'h070, 8'h17);
        status(33'h02);
        repeat (40) @(posedge mclk_in);
        status(33'h04);
        apb(1'b1, 12'h070, 8'h17);
        repeat (3) @(posedge mclk_in);
        search_none_in <= 1'b1;
        @(posedge mclk_in);
        search_none_in <= 1'b0;
        status(33'h10);
        test_done;
    end
    // Watchdog past the expected run of about 0.42 ms
    initial begin
        #600000;
        err_total++;
        test_done;
    end
endmodule
